// ===== rtl/iolc_line_drive.sv
// per-line pad driver: push-pull or open-drain
// assumes the pad wire is resolved from the enable outside the design
module iolc_line_drive import iolc_pkg::*; #(
    parameter int N = LINES
) (
    // control
    input  wire logic [N-1:0] out_value,
    input  wire logic [N-1:0] od_mode,
    // pad side
    output logic      [N-1:0] pad_out,
    output logic      [N-1:0] pad_oe
);
    // the masks below are plain bitwise, so any positive width is served
    if (N < 1) begin : g_bad_n
        $error("iolc_line_drive needs at least one line");
    end

    // open-drain drives a constant low; a high value only releases the pin
    assign pad_out = out_value & ~od_mode;
    assign pad_oe  = ~(od_mode & out_value) | ~od_mode;
endmodule // iolc_line_drive

// ===== rtl/iolc_pkg.sv
// package for the input-change and open-drain section of the I/O controller
// assumes one 40 MHz clock and an APB slave with 32-bit data
package iolc_pkg;
    localparam int LINES = 32;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CHG_IRQ_ENABLE  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CHG_IRQ_DISABLE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CHG_IRQ_MASK    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CHANGE_STATUS   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_OD_ENABLE       = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_OD_DISABLE      = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_OD_STATE        = 8'h18;

    // reset values
    localparam logic [LINES-1:0] RST_MASK   = 32'h0000_0000;
    localparam logic [LINES-1:0] RST_STATUS = 32'h0000_0000;
    localparam logic [LINES-1:0] RST_OD     = 32'h0000_0000;
    localparam logic [31:0]      RD_ZERO    = 32'h0000_0000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              write;
        logic [31:0]       wdata;
    } iolc_req_s;

    typedef enum logic [2:0] {
        IOLC_R_NONE,
        IOLC_R_MASK,
        IOLC_R_STATUS,
        IOLC_R_OD,
        IOLC_R_WO
    } iolc_rsel_e;

    // bitwise set/clear update of an enable vector
    function automatic logic [LINES-1:0] set_clr(
        input logic [LINES-1:0] cur,
        input logic [LINES-1:0] set_bits,
        input logic [LINES-1:0] clr_bits);
        set_clr = (cur | set_bits) & ~clr_bits;
    endfunction
endpackage

// ===== rtl/iolc_top.sv
// input-change detection and open-drain control for 32 I/O lines
// assumes pin levels synchronous to core_clk, APB master on the same clock
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - writing one to an enable bit turns that line's change interrupt on
// - writing one to a disable bit turns that line's change interrupt off
// - mask register reads one for each line whose change interrupt is on
// - status bit sets on any level change, stays until read or reset
// - reading status clears all bits; later changes are caught again
// - writing one to open-drain enable puts that line in open-drain mode
// - push-pull line: state bit zero, pin driven high and low from the first clock after reset
// - open-drain line: state bit one, pin only pulled low, high released
//
// Local design decisions: the APB slave port and the placing of the registers.
module iolc_top import iolc_pkg::*; (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // pins and controller data
    input  wire logic [LINES-1:0] pin_level,
    input  wire logic [LINES-1:0] out_value,
    output logic      [LINES-1:0] pad_out,
    output logic      [LINES-1:0] pad_oe,
    // interrupt
    output logic                  irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [LINES-1:0] mask_reg, mask_next;
    logic [LINES-1:0] status_reg, status_next;
    logic [LINES-1:0] od_reg, od_next;
    logic [LINES-1:0] level_reg;
    logic             level_valid_reg;
    logic [LINES-1:0] pad_out_reg, pad_oe_reg;
    logic [31:0]      prdata_reg;
    logic             pready_reg, pslverr_reg, irq_reg;

    iolc_req_s  req;
    iolc_rsel_e rsel;
    wire logic [LINES-1:0] change;
    wire logic [LINES-1:0] drv_out, drv_oe;
    wire logic             setup, wr, rd, status_rd;
    wire logic [31:0]      rd_value;
    wire logic             bad_addr;

    ////////////////////////////////////////////////////////////////////////
    // bus decode: answer one cycle after setup, zero wait states after that
    assign req       = '{addr: paddr, write: pwrite, wdata: pwdata};
    assign setup     = psel && !penable;
    assign wr        = setup && req.write;
    assign rd        = setup && !req.write;

    always_comb begin
        case (req.addr)
            OFS_CHG_IRQ_MASK:    rsel = IOLC_R_MASK;
            OFS_CHANGE_STATUS:   rsel = IOLC_R_STATUS;
            OFS_OD_STATE:        rsel = IOLC_R_OD;
            OFS_CHG_IRQ_ENABLE,
            OFS_CHG_IRQ_DISABLE,
            OFS_OD_ENABLE,
            OFS_OD_DISABLE:      rsel = IOLC_R_WO;
            default:             rsel = IOLC_R_NONE;
        endcase
    end

    assign bad_addr  = (rsel == IOLC_R_NONE);
    assign status_rd = rd && (rsel == IOLC_R_STATUS);

    assign rd_value = (rsel == IOLC_R_MASK)   ? mask_reg :
                      (rsel == IOLC_R_STATUS) ? status_reg :
                      (rsel == IOLC_R_OD)     ? od_reg :
                      RD_ZERO;

    ////////////////////////////////////////////////////////////////////////
    // register updates
    wire logic [LINES-1:0] we_ie = (wr && req.addr == OFS_CHG_IRQ_ENABLE)
                                   ? req.wdata : RST_MASK;
    wire logic [LINES-1:0] we_id = (wr && req.addr == OFS_CHG_IRQ_DISABLE)
                                   ? req.wdata : RST_MASK;
    wire logic [LINES-1:0] we_oe = (wr && req.addr == OFS_OD_ENABLE)
                                   ? req.wdata : RST_OD;
    wire logic [LINES-1:0] we_od = (wr && req.addr == OFS_OD_DISABLE)
                                   ? req.wdata : RST_OD;

    assign mask_next = set_clr(mask_reg, we_ie, we_id);
    assign od_next   = set_clr(od_reg, we_oe, we_od);

    // compare against the previous sample; first sample after reset
    // only primes the history so a reset does not fake a change
    assign change = level_valid_reg ? (pin_level ^ level_reg)
                                    : RST_STATUS;

    // the read returns the old value; a change in that same cycle survives
    assign status_next = (status_rd ? RST_STATUS : status_reg)
                         | change;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg        <= RST_MASK;
            status_reg      <= RST_STATUS;
            od_reg          <= RST_OD;
            level_reg       <= RST_STATUS;
            level_valid_reg <= 1'b0;
        end else begin
            mask_reg        <= mask_next;
            status_reg      <= status_next;
            od_reg          <= od_next;
            level_reg       <= pin_level;
            level_valid_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_reg  <= RD_ZERO;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup && bad_addr;
            prdata_reg  <= rd ? rd_value : RD_ZERO;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg     <= 1'b0;
            pad_out_reg <= RST_OD;
            pad_oe_reg  <= RST_OD;
        end else begin
            irq_reg     <= |(status_next & mask_next);
            pad_out_reg <= drv_out;
            pad_oe_reg  <= drv_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    iolc_line_drive #(.N(LINES)) u_drive (
        .out_value (out_value),
        .od_mode   (od_next),
        .pad_out   (drv_out),
        .pad_oe    (drv_oe)
    );

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq     = irq_reg;
    assign pad_out = pad_out_reg;
    assign pad_oe  = pad_oe_reg;
endmodule // iolc_top

// ===== sim/iolc_ext_circuit.sv
// outside circuits on the lines: pull-ups and low drivers
// assumes pad_oe high where the block drives the line
module iolc_ext_circuit import iolc_pkg::*; (
    // block side
    input  wire logic [31:0] pad_out,
    input  wire logic [31:0] pad_oe,
    // lines pulled low from outside
    input  wire logic [31:0] ext_low,
    // resolved level
    output logic      [31:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // released lines rise; any low driver wins
    assign pin_level = ~ext_low & (pad_out | ~pad_oe);
endmodule // iolc_ext_circuit

// ===== sim/iolc_top_monitor.sv
// checker on the ports of iolc_top, bound below
// assumes the one-cycle apb answer and registered pads
module iolc_top_monitor import iolc_pkg::*; (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        reset_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pads and irq
    input wire logic [31:0] out_value,
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire setup = psel && !penable;
    wire rd_en = setup && !pwrite && paddr == OFS_CHG_IRQ_ENABLE;
    wire dis_all = setup && pwrite && paddr == OFS_CHG_IRQ_DISABLE
        && pwdata == 32'hFFFF_FFFF;
////////////////////////////////////////
    property p_rdy; setup |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("long ready");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_wo; rd_en |=> prdata == RD_ZERO; endproperty
    a_wo: assert property (p_wo) else $error("wo read");
    property p_dis; dis_all |=> ##1 !irq; endproperty
    a_dis: assert property (p_dis) else $error("irq on");
    property p_fall; $fell(irq) |-> $past(setup); endproperty
    a_fall: assert property (p_fall) else $error("irq fell");
    // release only for a high value, never a driven one
    property p_out;
        $past(reset_n) |-> pad_out == ($past(out_value) & pad_oe);
    endproperty
    a_out: assert property (p_out) else $error("pad value");
    property p_low; $past(reset_n) |-> (pad_oe | $past(out_value)) == '1;
    endproperty
    a_low: assert property (p_low) else $error("pad off");
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
    c_dis: cover property (dis_all);
endmodule // iolc_top_monitor
bind iolc_top iolc_top_monitor iolc_top_monitor_inst (.core_clk,
    .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .out_value, .pad_out, .pad_oe, .irq);

// ===== sim/testbench.sv
// bench for iolc_top: apb master tasks and pin stimulus
// assumes the pull-up line model of iolc_ext_circuit
module testbench import iolc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        reset_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, pin_level, out_value, pad_out, pad_oe;
    logic [31:0] ext_low;
    int          fail_count, checks, cyc;
    always #12.5 core_clk = ~core_clk;
    iolc_top iolc_top_inst (.core_clk, .reset_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_level,
        .out_value, .pad_out, .pad_oe, .irq);
    iolc_ext_circuit iolc_ext_circuit_inst (.pad_out, .pad_oe, .ext_low,
        .pin_level);
////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask
    task automatic summarize();
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            $display("[FAIL] %0t timeout", $time);
            summarize();
        end
    end
    // lines start high so leaving reset is no change
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} <= '0;
        out_value <= 32'hFFFF_FFFF;
        ext_low <= 32'h0;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        // last offset is unmapped
        for (int i = 0; i < 8; i++) begin
            rd_chk(8'(i * 4), 32'h0);
        end
        chk({31'h0, err}, 32'h1);
        xfer(OFS_CHG_IRQ_ENABLE, 1'b1, 32'hF0F0_000F);
        xfer(OFS_CHG_IRQ_DISABLE, 1'b1, 32'h3);
        xfer(OFS_CHG_IRQ_ENABLE, 1'b1, 32'h0);
        xfer(OFS_CHG_IRQ_MASK, 1'b1, 32'hFFFF_FFFF);
        rd_chk(OFS_CHG_IRQ_MASK, 32'hF0F0_000C);
        out_value <= 32'hFFFF_FFEF;
        repeat (4) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        out_value <= 32'hFFFF_FFEB;
        repeat (4) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        rd_chk(OFS_CHANGE_STATUS, 32'h14);
        rd_chk(OFS_CHANGE_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        xfer(OFS_OD_ENABLE, 1'b1, 32'h3);
        xfer(OFS_OD_DISABLE, 1'b1, 32'h1);
        rd_chk(OFS_OD_STATE, 32'h2);
        chk(pad_oe, 32'hFFFF_FFFD);
        chk(pad_out, 32'hFFFF_FFE9);
        ext_low <= 32'h2;
        out_value <= 32'hFFFF_FFE9;
        repeat (4) @(posedge core_clk);
        chk(pad_oe, 32'hFFFF_FFFF);
        rd_chk(OFS_CHANGE_STATUS, 32'h2);
        // released open-drain line rises through the pull-up: a change
        xfer(OFS_CHG_IRQ_ENABLE, 1'b1, 32'h2);
        ext_low <= 32'h0;
        out_value <= 32'hFFFF_FFEB;
        repeat (4) @(posedge core_clk);
        chk(pad_oe, 32'hFFFF_FFFD);
        chk({31'h0, irq}, 32'h1);
        xfer(OFS_CHG_IRQ_DISABLE, 1'b1, 32'hFFFF_FFFF);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        // mid-run reset drops the pending change and all settings
        out_value <= 32'hFFFF_FFFF;
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_chk(OFS_CHANGE_STATUS, 32'h0);
        rd_chk(OFS_OD_STATE, 32'h0);
        repeat (2) @(posedge core_clk);
        summarize();
    end
endmodule // testbench
